// file: hdl/switch_matrix_map.svh
// Register map and field positions of the amplifier switch bank.
// Assumes byte addresses on a 32-bit register port.
`ifndef SWITCH_MATRIX_MAP_SVH
`define SWITCH_MATRIX_MAP_SVH

`define TIA_SW_ADDR      16'h215c
`define EXC_SW_ADDR      16'h2158
`define TIA_SW_RESET     12'h000
`define EXC_SW_RESET     3'h0
`define TIA_SW_W         12
`define EXC_SW_W         3
`define BIT_CAL_B        11
`define BIT_RSVD_HI      10
`define BIT_DIRECT_SENSE 9
`define BIT_COMMON_PATH  8
`define BIT_AUX_MATRIX   6
`define BIT_CAL_TO_SENSE 5
`define BIT_ELECTRODE_B  4
`define BIT_AIN_FOUR     3
`define BIT_AIN_THREE    2
`define BIT_EXC_THREE    2
`define BIT_EXC_TWO      1
`define BIT_EXC_CAL_A    0
`define READ_ZERO        32'h0000_0000

`endif

// file: hdl/switch_matrix_pkg.sv
// Types shared by the amplifier switch bank.
// Assumes the map header is compiled alongside.
package switch_matrix_pkg;

    typedef struct packed {
        logic cal_pin_b_to_amp_switch;
        logic direct_sense_switch;
        logic common_path_switch;
        logic aux_matrix_switch;
        logic cal_to_sense_switch;
        logic sensor_electrode_b_switch;
        logic analog_in_four_switch;
        logic analog_in_three_switch;
        logic excite_to_input_three_switch;
        logic excite_to_input_two_switch;
        logic excite_to_cal_a_switch;
    } switch_ctrl_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage : switch_matrix_pkg

// file: hdl/switch_matrix_tia_config.sv
// Switch control register bank for the amplifier input matrix.
// Assumes a single-cycle register port and one 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "switch_matrix_map.svh"

// What this block does
// - Bit 11 closes the calibration pin B switch to the amplifier input.
// - Bit 9 closes the direct sense electrode switch to the amplifier input.
// - Bit 8 drives the common path switch shared by the pin selections.
// - With the common path bit clear the direct sense switch may feed the input.
// - Bit 6 closes the auxiliary matrix switch.
// - Bit 5 closes the calibration path to the sense electrode input.
// - Bit 4 closes the second sensor electrode switch via the common path.
// - Bit 3 closes the fourth analog input switch via the common path.
// - Bit 2 closes the third analog input switch via the common path.
// - Excitation bit 2 joins the excitation node to analog input three.
// - Excitation bit 1 joins the excitation node to analog input two.
// - Excitation bit 0 joins the excitation node to calibration pin A.
// - The amplifier input register resets to zero with all switches open.
module switch_matrix_tia_config
    import switch_matrix_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [15:0]  reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output var  logic [31:0]  reg_rdata,
    output var  switch_ctrl_t sw_ctrl
);

    logic [`TIA_SW_W-1:0] tia_q;
    logic [`TIA_SW_W-1:0] tia_d;
    logic [`EXC_SW_W-1:0] exc_q;
    logic [`EXC_SW_W-1:0] exc_d;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    reg_req_t             req;
    logic                 wr_seen_q;

    // Address match
    function automatic logic hit(
        input logic [15:0] a,
        input logic [15:0] target
    );
        hit = (a == target);
    endfunction : hit

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    always_comb begin
        tia_d = tia_q;
        if (req.wr && hit(req.addr, `TIA_SW_ADDR)) begin
            tia_d = req.wdata[`TIA_SW_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tia_q <= `TIA_SW_RESET;
        end else begin
            tia_q <= tia_d;
        end
    end

    // Excitation switch field
    always_comb begin
        exc_d = exc_q;
        if (req.wr && hit(req.addr, `EXC_SW_ADDR)) begin
            exc_d = req.wdata[`EXC_SW_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            exc_q <= `EXC_SW_RESET;
        end else begin
            exc_q <= exc_d;
        end
    end

    always_comb begin
        rdata_d = `READ_ZERO;
        if (req.rd && hit(req.addr, `TIA_SW_ADDR)) begin
            rdata_d[`TIA_SW_W-1:0] = tia_q;
        end else if (req.rd && hit(req.addr, `EXC_SW_ADDR)) begin
            rdata_d[`EXC_SW_W-1:0] = exc_q;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= `READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    assign sw_ctrl.cal_pin_b_to_amp_switch = tia_q[`BIT_CAL_B];
    assign sw_ctrl.direct_sense_switch = tia_q[`BIT_DIRECT_SENSE];
    assign sw_ctrl.common_path_switch = tia_q[`BIT_COMMON_PATH];
    assign sw_ctrl.aux_matrix_switch = tia_q[`BIT_AUX_MATRIX];
    assign sw_ctrl.cal_to_sense_switch = tia_q[`BIT_CAL_TO_SENSE];
    assign sw_ctrl.sensor_electrode_b_switch = tia_q[`BIT_ELECTRODE_B];
    assign sw_ctrl.analog_in_four_switch = tia_q[`BIT_AIN_FOUR];
    assign sw_ctrl.analog_in_three_switch = tia_q[`BIT_AIN_THREE];
    assign sw_ctrl.excite_to_input_three_switch = exc_q[`BIT_EXC_THREE];
    assign sw_ctrl.excite_to_input_two_switch = exc_q[`BIT_EXC_TWO];
    assign sw_ctrl.excite_to_cal_a_switch = exc_q[`BIT_EXC_CAL_A];

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_tia_wr;
        reg_wr && hit(reg_addr, `TIA_SW_ADDR);
    endsequence

    sequence s_exc_wr;
        reg_wr && hit(reg_addr, `EXC_SW_ADDR);
    endsequence

    sequence s_tia_rd;
        reg_rd && hit(reg_addr, `TIA_SW_ADDR);
    endsequence

    sequence s_exc_rd;
        reg_rd && hit(reg_addr, `EXC_SW_ADDR);
    endsequence

    sequence s_other_rd;
        reg_rd && !hit(reg_addr, `TIA_SW_ADDR) && !hit(reg_addr, `EXC_SW_ADDR);
    endsequence

    sequence s_other_wr;
        reg_wr && !hit(reg_addr, `TIA_SW_ADDR) && !hit(reg_addr, `EXC_SW_ADDR);
    endsequence

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_seen_q <= 1'b0;
        end else if (reg_wr && (hit(reg_addr, `TIA_SW_ADDR) || hit(reg_addr, `EXC_SW_ADDR))) begin
            wr_seen_q <= 1'b1;
        end
    end

    chk_cal_b_follow: assert property (
        s_tia_wr |=> sw_ctrl.cal_pin_b_to_amp_switch == $past(reg_wdata[`BIT_CAL_B]))
        else $error("Calibration B switch does not follow write");

    chk_direct_sense_follow: assert property (
        s_tia_wr |=> sw_ctrl.direct_sense_switch == $past(reg_wdata[`BIT_DIRECT_SENSE]))
        else $error("Direct sense switch does not follow write");

    chk_common_path_follow: assert property (
        s_tia_wr |=> sw_ctrl.common_path_switch == $past(reg_wdata[`BIT_COMMON_PATH]))
        else $error("Common path switch does not follow write");

    chk_direct_sense_alone: assert property (
        s_tia_wr ##1 (!sw_ctrl.common_path_switch && !reg_wr)
        |-> ##1 $stable(sw_ctrl.direct_sense_switch))
        else $error("Direct sense switch changed without write");

    chk_aux_follow: assert property (
        s_tia_wr |=> sw_ctrl.aux_matrix_switch == $past(reg_wdata[`BIT_AUX_MATRIX]))
        else $error("Auxiliary switch does not follow write");

    chk_cal_sense_follow: assert property (
        s_tia_wr |=> sw_ctrl.cal_to_sense_switch == $past(reg_wdata[`BIT_CAL_TO_SENSE]))
        else $error("Calibration to sense switch does not follow write");

    chk_electrode_b_follow: assert property (
        s_tia_wr |=> sw_ctrl.sensor_electrode_b_switch == $past(reg_wdata[`BIT_ELECTRODE_B]))
        else $error("Second electrode switch does not follow write");

    chk_ain_four_follow: assert property (
        s_tia_wr |=> sw_ctrl.analog_in_four_switch == $past(reg_wdata[`BIT_AIN_FOUR]))
        else $error("Input four switch does not follow write");

    chk_ain_three_follow: assert property (
        s_tia_wr |=> sw_ctrl.analog_in_three_switch == $past(reg_wdata[`BIT_AIN_THREE]))
        else $error("Input three switch does not follow write");

    chk_exc_three_follow: assert property (
        s_exc_wr |=> sw_ctrl.excite_to_input_three_switch == $past(reg_wdata[`BIT_EXC_THREE]))
        else $error("Excitation input three switch wrong");

    chk_exc_two_follow: assert property (
        s_exc_wr |=> sw_ctrl.excite_to_input_two_switch == $past(reg_wdata[`BIT_EXC_TWO]))
        else $error("Excitation input two switch wrong");

    chk_exc_cal_follow: assert property (
        s_exc_wr |=> sw_ctrl.excite_to_cal_a_switch == $past(reg_wdata[`BIT_EXC_CAL_A]))
        else $error("Excitation calibration switch wrong");

    chk_reset_open: assert property (
        $rose(nrst) |-> (sw_ctrl == '0) && (reg_rdata == `READ_ZERO))
        else $error("Switches not open after reset");

    chk_readback_value: assert property (
        s_tia_wr ##1 (s_tia_rd and !reg_wr)
        |=> reg_rdata == 32'($past(reg_wdata[`TIA_SW_W-1:0], 2)))
        else $error("Readback differs from written value");

    chk_exc_readback: assert property (
        s_exc_wr ##1 (s_exc_rd and !reg_wr)
        |=> reg_rdata == 32'($past(reg_wdata[`EXC_SW_W-1:0], 2)))
        else $error("Excitation readback differs from written value");

    chk_reserved_readback: assert property (
        s_tia_wr ##1 (s_tia_rd and !reg_wr)
        |=> reg_rdata[`BIT_RSVD_HI] == $past(reg_wdata[`BIT_RSVD_HI], 2))
        else $error("Reserved bit readback differs");

    chk_tia_upper_zero: assert property (
        s_tia_rd |=> reg_rdata[31:`TIA_SW_W] == '0)
        else $error("Upper amplifier register bits not zero");

    chk_exc_upper_zero: assert property (
        s_exc_rd |=> reg_rdata[31:`EXC_SW_W] == '0)
        else $error("Upper excitation register bits not zero");

    chk_unmapped_rd_zero: assert property (
        s_other_rd |=> reg_rdata == `READ_ZERO)
        else $error("Unmapped read not zero");

    chk_unmapped_wr_hold: assert property (
        s_other_wr |=> $stable(sw_ctrl))
        else $error("Unmapped write changed switches");

    chk_no_write_hold: assert property (
        !reg_wr |=> $stable(sw_ctrl))
        else $error("Switches changed without write");

    chk_open_until_write: assert property (
        !wr_seen_q |-> sw_ctrl == '0)
        else $error("Switch closed before any write");

    chk_exc_keeps_tia: assert property (
        s_exc_wr |=> $stable(sw_ctrl[10:3]))
        else $error("Excitation write changed amplifier switches");

    chk_tia_keeps_exc: assert property (
        s_tia_wr |=> $stable(sw_ctrl[2:0]))
        else $error("Amplifier write changed excitation switches");

    chk_direct_sense_rd: assert property (
        s_tia_rd |=> reg_rdata[`BIT_DIRECT_SENSE] == $past(sw_ctrl.direct_sense_switch))
        else $error("Direct sense readback differs from switch");

    chk_common_path_rd: assert property (
        s_tia_rd |=> reg_rdata[`BIT_COMMON_PATH] == $past(sw_ctrl.common_path_switch))
        else $error("Common path readback differs from switch");

    chk_aux_rd: assert property (
        s_tia_rd |=> reg_rdata[`BIT_AUX_MATRIX] == $past(sw_ctrl.aux_matrix_switch))
        else $error("Auxiliary readback differs from switch");

    chk_electrode_b_rd: assert property (
        s_tia_rd |=> reg_rdata[`BIT_ELECTRODE_B] == $past(sw_ctrl.sensor_electrode_b_switch))
        else $error("Second electrode readback differs from switch");

    chk_ain_four_rd: assert property (
        s_tia_rd |=> reg_rdata[`BIT_AIN_FOUR] == $past(sw_ctrl.analog_in_four_switch))
        else $error("Input four readback differs from switch");

    chk_cal_b_rd: assert property (
        s_tia_rd |=> reg_rdata[`BIT_CAL_B] == $past(sw_ctrl.cal_pin_b_to_amp_switch))
        else $error("Calibration B readback differs from switch");

    chk_exc_cal_rd: assert property (
        s_exc_rd |=> reg_rdata[`BIT_EXC_CAL_A] == $past(sw_ctrl.excite_to_cal_a_switch))
        else $error("Excitation calibration readback differs from switch");

    chk_idle_rdata_zero: assert property (
        !reg_rd |=> reg_rdata == `READ_ZERO)
        else $error("Read data not zero outside read");

endmodule : switch_matrix_tia_config

`default_nettype wire

// file: verif/amp_input_matrix.sv
// Far-end model of the analog matrix in front of the amplifier input.
// Assumes switch controls are levels, 1 = closed.
`timescale 1ns/1ns
`default_nettype none
module amp_input_matrix
    import switch_matrix_pkg::*;
(
    input  wire switch_ctrl_t sw_ctrl,
    output var  logic         input_clash,
    output var  logic [2:0]   pin_paths
);
    // Direct path only with common open
    always_comb begin
        input_clash = sw_ctrl.common_path_switch & sw_ctrl.direct_sense_switch;
    end
    always_comb begin
        pin_paths = {sw_ctrl.sensor_electrode_b_switch, sw_ctrl.analog_in_four_switch,
                     sw_ctrl.analog_in_three_switch} & {3{sw_ctrl.common_path_switch}};
    end
endmodule : amp_input_matrix
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the switch register bank.
// Assumes the design and the far-end model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "switch_matrix_map.svh"
module testbench
    import switch_matrix_pkg::*;
;
    logic         clock = 1'b0;
    logic         nrst = 1'b0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [15:0]  reg_addr = 16'h0000;
    logic [31:0]  reg_wdata = 32'h0000_0000;
    logic [31:0]  reg_rdata;
    switch_ctrl_t sw_ctrl;
    logic         input_clash;
    logic [2:0]   pin_paths;
    logic [31:0]  tia = 32'h0;
    logic [31:0]  exc = 32'h0;
    logic [15:0]  a;
    int           bad_count = 0;
    int           compares = 0;

    always #10 clock = ~clock;

    switch_matrix_tia_config DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_ctrl(sw_ctrl));
    amp_input_matrix far_end (.sw_ctrl(sw_ctrl), .input_clash(input_clash), .pin_paths(pin_paths));

    task automatic end_of_test();
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    function automatic logic [31:0] sw_exp();
        return {21'h0, tia[11], tia[9], tia[8], tia[6:2], exc[2:0]};
    endfunction : sw_exp

    function automatic logic [31:0] rd_exp(input logic [15:0] ra);
        if (ra == `TIA_SW_ADDR) return tia;
        if (ra == `EXC_SW_ADDR) return exc;
        return `READ_ZERO;
    endfunction : rd_exp

    task automatic wr(input logic [15:0] wa, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= wa;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (wa == `TIA_SW_ADDR) tia = d & 32'hfff;
        else if (wa == `EXC_SW_ADDR) exc = d & 32'h7;
        #1;
        cmp("switches", sw_exp(), {21'h0, sw_ctrl});
        cmp("paths", {29'h0, tia[4:2] & {3{tia[8]}}}, {29'h0, pin_paths});
        cmp("clash", 32'h0, {31'h0, input_clash});
    endtask : wr

    task automatic wr_rd(input logic [15:0] wa, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= wa;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        if (wa == `TIA_SW_ADDR) tia = d & 32'hfff;
        else if (wa == `EXC_SW_ADDR) exc = d & 32'h7;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        cmp("write read", rd_exp(wa), reg_rdata);
    endtask : wr_rd

    task automatic sw_write(input logic [15:0] wa, input logic [31:0] d);
        if (wa == `TIA_SW_ADDR && d[8]) begin
            d[9] = 1'b0;
            if (tia[9]) wr(wa, tia & ~32'h200);
        end
        wr(wa, d);
    endtask : sw_write

    task automatic rd(input logic [15:0] ra);
        @(posedge clock);
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        cmp("read", rd_exp(ra), reg_rdata);
        @(posedge clock);
        #1;
        cmp("read idle", `READ_ZERO, reg_rdata);
    endtask : rd

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hfaa71386));
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        #1;
        cmp("reset", `READ_ZERO, {21'h0, sw_ctrl});
        rd(`TIA_SW_ADDR);
        for (int i = 0; i < 12; i++) sw_write(`TIA_SW_ADDR, 32'h1 << i);
        for (int i = 0; i < 3; i++) sw_write(`EXC_SW_ADDR, 32'h1 << i);
        sw_write(`TIA_SW_ADDR, 32'hffff_ffff);
        rd(`TIA_SW_ADDR);
        wr(16'h2160, 32'hffff_ffff);
        rd(16'h2160);
        wr_rd(`TIA_SW_ADDR, 32'hffff_fcff);
        wr_rd(`EXC_SW_ADDR, 32'hffff_fffd);
        repeat (300) begin
            case ($urandom % 3)
                0: a = `TIA_SW_ADDR;
                1: a = `EXC_SW_ADDR;
                default: a = 16'($urandom);
            endcase
            sw_write(a, $urandom);
            rd(a);
            wr_rd(a, $urandom & 32'hffff_feff);
        end
        @(posedge clock);
        nrst <= 1'b0;
        tia = 32'h0;
        exc = 32'h0;
        #1;
        cmp("mid reset", `READ_ZERO, {21'h0, sw_ctrl});
        @(posedge clock);
        nrst <= 1'b1;
        rd(`TIA_SW_ADDR);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
